// >>> include/sct_cfg.svh
// constants for the sample clock delay and timestamp block
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

`define SCT_DATA_W        8
`define SCT_DLY_W         8
`define SCT_CNT_W         9
`define SCT_SLOW_CYC      9'h100
`define SCT_FAST_CYC      9'h180
`define SCT_FAST_STEPS    9'h004
`define SCT_FAST_STEP_CYC (`SCT_FAST_CYC / `SCT_FAST_STEPS)
`define SCT_DLY_RST       8'h00
`define SCT_SMP_RST       8'h00

`endif

// >>> include/sct_pkg.sv
// types shared by the delay ramp and the sample path
`include "sct_cfg.svh"
package sct_pkg;

  // ramp controller states, one-hot
  typedef enum logic [1:0] {
    RMP_IDLE = 2'b01,
    RMP_RUN  = 2'b10
  } sct_ramp_st_t;

  // whole state of the ramp controller
  typedef struct packed {
    sct_ramp_st_t            st;
    logic [`SCT_DLY_W-1:0]   coarse;
    logic [`SCT_DLY_W-1:0]   target;
    logic [`SCT_CNT_W-1:0]   cnt;
    logic                    step;
    logic                    jump;
  } sct_ramp_t;

  // state of the top level, apart from the ramp status copies coarse_q and busy_q
  typedef struct packed {
    logic [`SCT_DATA_W-1:0]  smp_a;
    logic [`SCT_DATA_W-1:0]  smp_b;
    logic [`SCT_DATA_W-1:0]  fall_hold;
    logic                    valid;
    logic                    mark;
    logic                    sysref_d1;
    logic                    sysref_cap;
    logic                    inv;
    logic [`SCT_DLY_W-1:0]   fine;
    logic                    change;
  } sct_top_t;

endpackage : sct_pkg

// >>> src/sct_ramp.sv
// coarse aperture delay ramp controller
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_ramp (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  wr_in,
  input  wire logic [`SCT_DLY_W-1:0] target_in,
  input  wire logic                  ramp_en_in,
  input  wire logic                  fast_in,
  output logic      [`SCT_DLY_W-1:0] coarse_out,
  output logic                       busy_out,
  output logic                       step_out,
  output logic                       jump_out
);

  // cycles between single steps for the chosen speed
  function automatic logic [`SCT_CNT_W-1:0] step_period(input logic fast);
    step_period = fast ? `SCT_FAST_STEP_CYC : `SCT_SLOW_CYC;
  endfunction : step_period

  sct_pkg::sct_ramp_t r_q;  // registered state
  sct_pkg::sct_ramp_t r_d;  // next state

  // next-state logic
  always_comb begin
    r_d      = r_q;
    r_d.step = 1'b0;
    r_d.jump = 1'b0;
    if (wr_in) begin
      if (ramp_en_in) begin
        // each write restarts the ramp from the present setting
        r_d.target = target_in;
        r_d.cnt    = '0;
        r_d.st     = (target_in == r_q.coarse) ? sct_pkg::RMP_IDLE
                                               : sct_pkg::RMP_RUN;
      end else begin
        // direct load, link may glitch
        r_d.coarse = target_in;
        r_d.target = target_in;
        r_d.jump   = (target_in != r_q.coarse);
        r_d.st     = sct_pkg::RMP_IDLE;
      end
    end else begin
      case (r_q.st)
        sct_pkg::RMP_IDLE: begin
          r_d.cnt = '0;
        end
        sct_pkg::RMP_RUN: begin
          if (!ramp_en_in) begin
            // ramp switched off midway: finish at once
            r_d.coarse = r_q.target;
            r_d.jump   = 1'b1;
            r_d.st     = sct_pkg::RMP_IDLE;
          end else if (r_q.cnt >= step_period(fast_in) - 9'h001) begin
            // one lsb toward the target
            r_d.cnt    = '0;
            r_d.step   = 1'b1;
            r_d.coarse = (r_q.target > r_q.coarse) ? r_q.coarse + 8'h01
                                                   : r_q.coarse - 8'h01;
            if (r_d.coarse == r_q.target) begin
              r_d.st = sct_pkg::RMP_IDLE;
            end
          end else begin
            r_d.cnt = r_q.cnt + 9'h001;
          end
        end
        default: begin
          r_d.st = sct_pkg::RMP_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_q.st     <= sct_pkg::RMP_IDLE;
      r_q.coarse <= `SCT_DLY_RST;
      r_q.target <= `SCT_DLY_RST;
      r_q.cnt    <= '0;
      r_q.step   <= 1'b0;
      r_q.jump   <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign coarse_out = r_q.coarse;
  assign busy_out   = (r_q.st == sct_pkg::RMP_RUN);
  assign step_out   = r_q.step;
  assign jump_out   = r_q.jump;

  // cycles since the last visible step or write, for checking only
  logic [`SCT_CNT_W:0] since_q;
  // a step was seen since the last write; first gap after a write is
  // one cycle longer and is not a step-to-step spacing
  logic                stepped_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || wr_in || step_out) begin
      since_q <= '0;
    end else begin
      since_q <= since_q + 10'h001;
    end
  end

  // step history flag, cleared by every write
  always_ff @(posedge clk_in) begin
    if (rst_in || wr_in) begin
      stepped_q <= 1'b0;
    end else if (step_out) begin
      stepped_q <= 1'b1;
    end
  end

  a_direct_load: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_in && !ramp_en_in |=> coarse_out == $past(target_in))
    else $error("direct coarse write not applied");
  a_slow_gap: assert property (@(posedge clk_in) disable iff (rst_in)
    step_out && stepped_q && !fast_in && !$past(fast_in)
      |-> since_q == 10'd255)
    else $error("slow ramp step spacing wrong");
  a_fast_gap: assert property (@(posedge clk_in) disable iff (rst_in)
    step_out && stepped_q && fast_in && $past(fast_in)
      |-> since_q == 10'd95)
    else $error("fast ramp step spacing wrong");
  a_ramp_unit: assert property (@(posedge clk_in) disable iff (rst_in)
    step_out |-> (coarse_out == $past(coarse_out) + 8'h01) ||
                 (coarse_out == $past(coarse_out) - 8'h01))
    else $error("ramp step not one lsb");
  a_ramp_start: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_in && ramp_en_in && target_in != coarse_out
      |=> busy_out && $stable(coarse_out))
    else $error("ramp write did not start ramp");
  c_ramp_done: cover property (@(posedge clk_in) disable iff (rst_in)
    busy_out ##1 !busy_out && step_out);

endmodule : sct_ramp

// >>> src/sct_top.sv
// sampling clock selection, timestamp mark and aperture delay control
`timescale 1ns/1ps
`include "sct_cfg.svh"
// Function
// - mark status only while marking enabled
// - mark replaces lsb of each 8-bit sample
// - trigger taken alongside the sample it marks
// - dual mode: one sample per clock, rising
// - single mode: rising and falling edge samples
// - core, processing and serial path share clock
// - reference captured on a fixed clock edge
// - invert delays sampling by half period, in single mode only
// - invert, coarse, fine independent and additive
// - delay shifts all clocks and reference capture
// - delay may change live, may upset link
// - ramp: 1 per 256 or 4 per 384
// - write while ramp enabled starts new ramp
module sct_top (
  input  wire logic                  CLK_IN,
  input  wire logic                  SYS_RST_IN,
  input  wire logic                  LINK_MODE_SELECT_IN,
  input  wire logic [`SCT_DATA_W-1:0] CH_A_SAMPLE_IN,
  input  wire logic [`SCT_DATA_W-1:0] CH_B_SAMPLE_IN,
  input  wire logic                  TRIGGER_MARK_IN,
  input  wire logic                  SAMPLE_MARK_EN_IN,
  input  wire logic                  SYSREF_IN,
  input  wire logic                  HALF_PERIOD_INVERT_IN,
  input  wire logic [`SCT_DLY_W-1:0] COARSE_APERTURE_DELAY_IN,
  input  wire logic                  COARSE_WR_IN,
  input  wire logic [`SCT_DLY_W-1:0] FINE_APERTURE_DELAY_IN,
  input  wire logic                  DELAY_RAMP_ENABLE_IN,
  input  wire logic                  DELAY_RAMP_SPEED_IN,
  output logic      [`SCT_DATA_W-1:0] SAMPLE_A_OUT,
  output logic      [`SCT_DATA_W-1:0] SAMPLE_B_OUT,
  output logic                       SAMPLE_VALID_OUT,
  output logic                       MARK_STATUS_OUT,
  output logic                       SYSREF_CAPTURED_OUT,
  output logic                       HALF_PERIOD_INVERT_OUT,
  output logic      [`SCT_DLY_W-1:0] COARSE_EFFECTIVE_OUT,
  output logic      [`SCT_DLY_W-1:0] FINE_EFFECTIVE_OUT,
  output logic                       DELAY_RAMP_BUSY_OUT,
  output logic                       DELAY_UPSET_OUT
);

  // mode codes of the link mode select input
  localparam logic MODE_DUAL   = 1'b0;  // two channels, rising edge only
  localparam logic MODE_SINGLE = 1'b1;  // one channel, both edges

  // replace the lsb with the mark when marking is on
  function automatic logic [`SCT_DATA_W-1:0] put_mark(
    input logic [`SCT_DATA_W-1:0] smp,
    input logic                   en,
    input logic                   mark);
    put_mark = en ? {smp[`SCT_DATA_W-1:1], mark} : smp;
  endfunction : put_mark

  sct_pkg::sct_top_t s_q;  // registered state
  sct_pkg::sct_top_t s_d;  // next state

  logic [`SCT_DLY_W-1:0] coarse_eff;  // ramped coarse setting
  logic                  ramp_busy;   // ramp in progress
  logic                  coarse_jump; // coarse changed in one go

  // coarse delay ramp
  sct_ramp u_ramp (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .wr_in      (COARSE_WR_IN),
    .target_in  (COARSE_APERTURE_DELAY_IN),
    .ramp_en_in (DELAY_RAMP_ENABLE_IN),
    .fast_in    (DELAY_RAMP_SPEED_IN),
    .coarse_out (coarse_eff),
    .busy_out   (ramp_busy),
    .step_out   (),
    .jump_out   (coarse_jump)
  );

  // next-state logic; one clock drives sampling, marking and output
  always_comb begin
    s_d           = s_q;
    s_d.valid     = 1'b1;
    // fall sample held so an inverted clock can pair it with next rise
    s_d.fall_hold = CH_B_SAMPLE_IN;
    case (LINK_MODE_SELECT_IN)
      MODE_DUAL: begin
        // each channel once per clock on the rising edge
        s_d.smp_a = CH_A_SAMPLE_IN;
        s_d.smp_b = CH_B_SAMPLE_IN;
      end
      MODE_SINGLE: begin
        if (HALF_PERIOD_INVERT_IN) begin
          // half period later: last fall becomes first of the pair
          s_d.smp_a = s_q.fall_hold;
          s_d.smp_b = CH_A_SAMPLE_IN;
        end else begin
          // rising then falling edge sample
          s_d.smp_a = CH_A_SAMPLE_IN;
          s_d.smp_b = CH_B_SAMPLE_IN;
        end
      end
      default: begin
        s_d.smp_a = CH_A_SAMPLE_IN;
        s_d.smp_b = CH_B_SAMPLE_IN;
      end
    endcase
    // trigger taken in the same cycle as the samples it marks
    s_d.smp_a = put_mark(s_d.smp_a, SAMPLE_MARK_EN_IN,
                         TRIGGER_MARK_IN);
    s_d.smp_b = put_mark(s_d.smp_b, SAMPLE_MARK_EN_IN,
                         TRIGGER_MARK_IN);
    // no status at all with marking off
    s_d.mark  = SAMPLE_MARK_EN_IN & TRIGGER_MARK_IN;
    // reference caught on a fixed edge; the delay moves that edge too
    s_d.sysref_d1  = SYSREF_IN;
    s_d.sysref_cap = SYSREF_IN & ~s_q.sysref_d1;
    // invert and fine act on their own, beside the coarse ramp
    s_d.inv  = HALF_PERIOD_INVERT_IN;
    s_d.fine = FINE_APERTURE_DELAY_IN;
    // flag any unramped change; the link may lose lock here
    s_d.change = coarse_jump |
                 (HALF_PERIOD_INVERT_IN != s_q.inv) |
                 (FINE_APERTURE_DELAY_IN != s_q.fine);
  end

  // state register
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      s_q.smp_a      <= `SCT_SMP_RST;
      s_q.smp_b      <= `SCT_SMP_RST;
      s_q.fall_hold  <= `SCT_SMP_RST;
      s_q.valid      <= 1'b0;
      s_q.mark       <= 1'b0;
      s_q.sysref_d1  <= 1'b0;
      s_q.sysref_cap <= 1'b0;
      s_q.inv        <= 1'b0;
      s_q.fine       <= `SCT_DLY_RST;
      s_q.change     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ramp status one flop later so every output leaves a register
  logic [`SCT_DLY_W-1:0] coarse_q;  // copy of ramped coarse
  logic                  busy_q;    // copy of ramp busy
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      coarse_q <= `SCT_DLY_RST;
      busy_q   <= 1'b0;
    end else begin
      coarse_q <= coarse_eff;
      busy_q   <= ramp_busy;
    end
  end

  assign SAMPLE_A_OUT           = s_q.smp_a;
  assign SAMPLE_B_OUT           = s_q.smp_b;
  assign SAMPLE_VALID_OUT       = s_q.valid;
  assign MARK_STATUS_OUT        = s_q.mark;
  assign SYSREF_CAPTURED_OUT    = s_q.sysref_cap;
  assign HALF_PERIOD_INVERT_OUT = s_q.inv;
  assign COARSE_EFFECTIVE_OUT   = coarse_q;
  assign FINE_EFFECTIVE_OUT     = s_q.fine;
  assign DELAY_RAMP_BUSY_OUT    = busy_q;
  assign DELAY_UPSET_OUT        = s_q.change;

  // checks
  a_mark_off: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !$past(SAMPLE_MARK_EN_IN) && $past(!SYS_RST_IN) |-> !MARK_STATUS_OUT)
    else $error("mark status while marking disabled");
  a_mark_lsb: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $past(SAMPLE_MARK_EN_IN) && $past(!SYS_RST_IN)
      |-> SAMPLE_A_OUT[0] == $past(TRIGGER_MARK_IN) &&
          SAMPLE_B_OUT[0] == $past(TRIGGER_MARK_IN))
    else $error("sample lsb does not carry mark");
  a_mark_align: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    SAMPLE_MARK_EN_IN && TRIGGER_MARK_IN ##1 !SAMPLE_MARK_EN_IN
      |-> MARK_STATUS_OUT)
    else $error("mark not with its sample");
  a_dual_pass: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $past(LINK_MODE_SELECT_IN == MODE_DUAL) && $past(!SYS_RST_IN)
      |-> SAMPLE_A_OUT[7:1] == $past(CH_A_SAMPLE_IN[7:1]) &&
          SAMPLE_B_OUT[7:1] == $past(CH_B_SAMPLE_IN[7:1]))
    else $error("dual mode samples wrong");
  a_single_order: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $past(LINK_MODE_SELECT_IN == MODE_SINGLE && !HALF_PERIOD_INVERT_IN)
      && $past(!SYS_RST_IN)
      |-> SAMPLE_A_OUT[7:1] == $past(CH_A_SAMPLE_IN[7:1]) &&
          SAMPLE_B_OUT[7:1] == $past(CH_B_SAMPLE_IN[7:1]))
    else $error("single mode edge order wrong");
  a_single_inv: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $past(LINK_MODE_SELECT_IN == MODE_SINGLE && HALF_PERIOD_INVERT_IN)
      && $past(!SYS_RST_IN, 2)
      |-> SAMPLE_A_OUT[7:1] == $past(CH_B_SAMPLE_IN[7:1], 2) &&
          SAMPLE_B_OUT[7:1] == $past(CH_A_SAMPLE_IN[7:1]))
    else $error("inverted clock not half period later");
  a_delay_indep: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $stable(COARSE_APERTURE_DELAY_IN) && !COARSE_WR_IN && !ramp_busy
      ##1 !COARSE_WR_IN |=> $stable(coarse_q) &&
      FINE_EFFECTIVE_OUT == $past(FINE_APERTURE_DELAY_IN))
    else $error("fine or invert disturbed coarse");
  a_sysref_cap: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !SYSREF_IN ##1 SYSREF_IN |=> SYSREF_CAPTURED_OUT ##1 !SYSREF_CAPTURED_OUT)
    else $error("reference edge not captured once");
  a_upset_flag: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    COARSE_WR_IN && !DELAY_RAMP_ENABLE_IN &&
      COARSE_APERTURE_DELAY_IN != coarse_eff |=> ##1 DELAY_UPSET_OUT)
    else $error("direct coarse change not flagged");

  c_single_inv: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    LINK_MODE_SELECT_IN && HALF_PERIOD_INVERT_IN ##1 SAMPLE_VALID_OUT);
  c_marked: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    MARK_STATUS_OUT);
  c_ramp: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    DELAY_RAMP_BUSY_OUT ##1 !DELAY_RAMP_BUSY_OUT);
  c_sysref: cover property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    SYSREF_CAPTURED_OUT);

endmodule : sct_top

// >>> bench/sct_src_model.sv
// far-side model: analog samples, trigger source and timing reference
`timescale 1ns/1ps
`include "sct_cfg.svh"
module sct_src_model #(
  parameter int R_LNK = 1, // link rate factor
  parameter int F_OCT = 1, // octets per frame
  parameter int K_FRM = 4, // frames per multiframe
  parameter int N_DIV = 1  // integer divider, positive
) (
  input  wire logic                   clk_in,
  input  wire logic                   run_in,
  output logic      [`SCT_DATA_W-1:0] ch_a_out,
  output logic      [`SCT_DATA_W-1:0] ch_b_out,
  output logic                        trig_out,
  output logic                        sysref_out
);
  // reference period in clocks, a whole multiframe multiple
  localparam int PERIOD = (10 * F_OCT * K_FRM * N_DIV) / R_LNK;
  int seed  = 81645; // fixed seed for repeatable runs
  int phase = 0;     // position inside reference period

  initial begin
    ch_a_out   = 8'h00;
    ch_b_out   = 8'h00;
    trig_out   = 1'b0;
    sysref_out = 1'b0;
  end

  // change only at falling edge so the rising edge sees settled levels
  always @(negedge clk_in) begin
    ch_a_out <= 8'($random(seed));
    ch_b_out <= 8'($random(seed));
    trig_out <= 1'($random(seed));
    // periodic reference, held high half a period
    if (run_in) begin
      phase <= (phase + 1) % PERIOD;
    end
    sysref_out <= run_in && (phase < PERIOD / 2);
  end
endmodule : sct_src_model

// >>> bench/tb_sample_clock_delay_and_timestamp.sv
// self-checking bench for the sample clock delay and timestamp block
`timescale 1ns/1ps
`include "sct_cfg.svh"
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb_sample_clock_delay_and_timestamp;
  logic       clk, rst, mode, mark_en, inv, cwr, ramp_en, speed, run;
  logic [7:0] coarse, fine;               // delay controls
  logic [7:0] ch_a, ch_b;                 // far-side samples
  logic       trig, sysref;               // far-side strobes
  logic [7:0] smp_a, smp_b, coarse_o, fine_o;
  logic       vld, mark, cap, inv_o, busy, upset;
  logic [7:0] pb, pf;                     // previous fall sample, fine
  logic       ps, pi;                     // previous reference, invert
  int         error_cnt = 0;
  int         checks = 0;
  int         skip = 0;                   // cycles left unchecked
  int         cyc_cnt = 0;

  sct_src_model sct_src_model_inst (.clk_in(clk), .run_in(run),
    .ch_a_out(ch_a), .ch_b_out(ch_b), .trig_out(trig), .sysref_out(sysref));

  sct_top sct_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst),
    .LINK_MODE_SELECT_IN(mode), .CH_A_SAMPLE_IN(ch_a),
    .CH_B_SAMPLE_IN(ch_b), .TRIGGER_MARK_IN(trig),
    .SAMPLE_MARK_EN_IN(mark_en), .SYSREF_IN(sysref),
    .HALF_PERIOD_INVERT_IN(inv), .COARSE_APERTURE_DELAY_IN(coarse),
    .COARSE_WR_IN(cwr), .FINE_APERTURE_DELAY_IN(fine),
    .DELAY_RAMP_ENABLE_IN(ramp_en), .DELAY_RAMP_SPEED_IN(speed),
    .SAMPLE_A_OUT(smp_a), .SAMPLE_B_OUT(smp_b), .SAMPLE_VALID_OUT(vld),
    .MARK_STATUS_OUT(mark), .SYSREF_CAPTURED_OUT(cap),
    .HALF_PERIOD_INVERT_OUT(inv_o), .COARSE_EFFECTIVE_OUT(coarse_o),
    .FINE_EFFECTIVE_OUT(fine_o), .DELAY_RAMP_BUSY_OUT(busy),
    .DELAY_UPSET_OUT(upset));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the expected run of about 2000 cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt > 8000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // reference model of the sample path, compared every cycle except the skip cycles
  task automatic run_cycles(input int n);
    logic [7:0] ea, eb;
    logic       hm;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      hm = mode & inv; // inverted single mode shifts pairing
      ea = hm ? pb : ch_a;
      eb = hm ? ch_a : ch_b;
      if (mark_en) begin
        ea[0] = trig;
        eb[0] = trig;
      end
      #1;
      if (skip > 0) begin
        skip--;
      end else begin
        `CHK(smp_a, ea)
        `CHK(smp_b, eb)
        `CHK(mark, mark_en & trig)
        `CHK(vld, 1'b1)
        `CHK(cap, sysref & ~ps)
        `CHK(inv_o, inv)
        `CHK(fine_o, fine)
        `CHK(upset, (fine != pf) | (inv != pi))
      end
      pb = ch_b;
      ps = sysref;
      pf = fine;
      pi = inv;
      @(negedge clk);
      if (i % 7 == 3) fine = fine + 8'h35;
    end
  endtask : run_cycles

  // one-cycle write strobe for the coarse value
  task automatic coarse_wr(input logic [7:0] v);
    @(negedge clk);
    coarse = v;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
  endtask : coarse_wr

  // value must land within a few cycles with the given upset count
  task automatic watch_jump(input logic [7:0] v, input int ups);
    int n;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (upset === 1'b1) n++;
    end
    `CHK(coarse_o, v)
    `CHK(n, ups)
  endtask : watch_jump

  // steps of one lsb at a fixed spacing, no upset while ramping
  task automatic ramp_watch(input logic [7:0] tgt, input int per);
    int last, cyc, ups;
    logic [7:0] pv;
    last = -1;
    ups = 0;
    pv = coarse_o;
    for (cyc = 0; cyc < 3000; cyc++) begin
      @(posedge clk);
      #1;
      if (cyc == 4) `CHK(busy, 1'b1)
      if (upset === 1'b1) ups++;
      if (coarse_o !== pv) begin
        `CHK(coarse_o, tgt > pv ? pv + 8'h01 : pv - 8'h01)
        if (last >= 0) `CHK(cyc - last, per)
        last = cyc;
        pv = coarse_o;
      end
      if (cyc > 4 && coarse_o === tgt) break;
    end
    `CHK(busy, 1'b0)
    `CHK(ups, 0)
  endtask : ramp_watch

  initial begin
    {mode, mark_en, inv, cwr, ramp_en, speed, run} = 7'h00;
    coarse = 8'h00;
    fine = 8'h00;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    `CHK(vld, 1'b0)
    @(negedge clk);
    rst = 1'b0;
    run = 1'b1;
    skip = 2; // previous-value trackers not yet primed
    run_cycles(60);
    mark_en = 1'b1;
    run_cycles(60);
    inv = 1'b1; // dual mode: invert shows only on its status and the upset flag
    run_cycles(10);
    inv = 1'b0;
    run_cycles(10);
    mode = 1'b1;
    skip = 2;
    run_cycles(60);
    inv = 1'b1;
    skip = 2;
    run_cycles(60);
    mark_en = 1'b0;
    run_cycles(40);
    // direct coarse writes, boundary values and a repeat
    coarse_wr(8'h5A);
    watch_jump(8'h5A, 1);
    coarse_wr(8'h5A);
    watch_jump(8'h5A, 0);
    coarse_wr(8'hFF);
    watch_jump(8'hFF, 1);
    coarse_wr(8'h00);
    watch_jump(8'h00, 1);
    // slow then fast ramps
    ramp_en = 1'b1;
    coarse_wr(8'h02);
    ramp_watch(8'h02, 256);
    speed = 1'b1;
    coarse_wr(8'h06);
    ramp_watch(8'h06, 96);
    // new write mid-ramp turns the ramp round
    coarse_wr(8'h20);
    repeat (200) @(negedge clk);
    coarse_wr(8'h03);
    ramp_watch(8'h03, 96);
    // dropping the enable mid-ramp jumps straight to target
    speed = 1'b0;
    coarse_wr(8'h40);
    repeat (20) @(negedge clk);
    ramp_en = 1'b0;
    watch_jump(8'h40, 1);
    final_report();
  end
endmodule : tb_sample_clock_delay_and_timestamp
